//--- irq_ctrl.sv
// Host interface interrupt logic with register port
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module irq_ctrl
    import irq_pkg::*;
(
    input  wire logic        clock_i,            // System clock, 50 MHz
    input  wire logic        rst_i,              // Async reset, active high
    input  wire logic [7:0]  addr_i,             // Register byte address
    input  wire logic [31:0] wdata_i,            // Write data
    input  wire logic        wr_i,               // Write strobe
    input  wire logic        rd_i,               // Read strobe
    output logic      [31:0] rdata_o,            // Read data, cycle after strobe
    input  wire logic        cmd_ready_flag_i,   // Command ready status flag
    input  wire logic        status_valid_flag_i,// Status valid flag
    input  wire logic        response_ready_flag_i, // Response ready flag
    input  wire logic        locality_request_i, // A locality requests use
    input  wire logic        locality_granted_i, // Requesting locality is active
    input  wire logic [4:0]  locality_state_reg_i, // Locality state register
    input  wire logic        established_flag_i, // Established flag
    input  wire logic        est_reset_req_i,    // Established reset request
    input  wire logic        ready_req_i,        // Software wrote ready request
    input  wire logic        idle_flag_i,        // Idle status
    input  wire logic        start_write_i,      // Start field written
    input  wire logic [3:0]  start_value_i,      // Value written to start
    input  wire logic        start_busy_i,       // Start field still set
    input  wire logic        cancel_i,           // Command cancel pulse
    input  wire logic        executing_i,        // A command is executing
    output logic             abort_cmd_o,        // Abort pulse to command engine
    output logic             irq_active_o,       // Interrupt asserted level
    output logic             serial_irq_line_o,  // Serial interrupt line out
    output logic             serial_irq_line_oe_o // Serial line drive enable
);
    logic [31:0] rdata_ff, nxt_rdata;
    logic        fgate_ff, nxt_fgate;
    logic [1:0]  ftype_ff, nxt_ftype;
    logic [7:0]  fen_ff, nxt_fen;
    logic [7:0]  fsts_ff, nxt_fsts;
    logic [3:0]  chan_ff, nxt_chan;
    logic        bgate_ff, nxt_bgate;
    logic [3:0]  ben_ff, nxt_ben;
    logic [3:0]  bsts_ff, nxt_bsts;
    logic [7:0]  fset;
    logic [3:0]  bset;
    logic        wr_fen, wr_fsts, wr_vec, wr_ben, wr_bsts;

    // Write decode
    assign wr_fen  = wr_i && addr_i == FIFO_EN_OFS;
    assign wr_fsts = wr_i && addr_i == FIFO_STS_OFS;
    assign wr_vec  = wr_i && addr_i == VECTOR_OFS;
    assign wr_ben  = wr_i && addr_i == BUF_EN_OFS;
    assign wr_bsts = wr_i && addr_i == BUF_STS_OFS;

    // One-write clear with set winning over clear
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                       input logic wr, input logic [7:0] data);
        w1c = (cur & ~(wr ? data : 8'h00)) | set;
    endfunction : w1c

    // Previous-cycle copies of the watched flags
    logic       cmd_ready_q, status_valid_q, response_q, granted_q;
    logic [4:0] loc_state_q;
    logic       idle_q, busy_q, est_q;
    logic       waited_ff, nxt_waited;
    logic       est_arm_ff, nxt_est_arm;
    logic       rdy_arm_ff, nxt_rdy_arm;
    logic       run_arm_ff, nxt_run_arm;
    logic       abort_ff, nxt_abort;

    // Cause detection and request tracking
    always_comb
    begin
        fset = 8'h00;
        bset = 4'h0;
        nxt_waited  = waited_ff;
        nxt_est_arm = est_arm_ff || est_reset_req_i;
        nxt_rdy_arm = rdy_arm_ff || ready_req_i;
        nxt_run_arm = run_arm_ff;
        fset[CMD_RDY_BIT] = cmd_ready_flag_i && !cmd_ready_q;         // [RULE3]
        fset[STSV_BIT]    = status_valid_flag_i && !status_valid_q;   // [RULE6]
        fset[RESP_BIT]    = response_ready_flag_i && !response_q
                            && status_valid_flag_i;                   // [RULE7]
        // Grant held back by another active locality
        if (locality_request_i && !locality_granted_i && loc_state_q[0])
            nxt_waited = 1'b1;
        if (locality_granted_i && !granted_q)
        begin
            fset[LOC_BIT] = waited_ff;                                // [RULE5]
            nxt_waited    = 1'b0;
        end
        // Only a change away from an assigned locality counts
        bset[B_LOC_BIT] = (locality_state_reg_i[4:2] != loc_state_q[4:2])
                          && loc_state_q[0];                          // [RULE13] [RULE14]
        if (est_arm_ff && established_flag_i && !est_q)
        begin
            bset[B_EST_BIT] = 1'b1;                                   // [RULE15]
            nxt_est_arm     = est_reset_req_i;
        end
        if (rdy_arm_ff && !idle_flag_i && idle_q)
        begin
            bset[B_RDY_BIT] = 1'b1;                                   // [RULE16]
            nxt_rdy_arm     = ready_req_i;
        end
        if (start_write_i && start_value_i == START_LAUNCH)
            nxt_run_arm = 1'b1;
        if (run_arm_ff && ((!start_busy_i && busy_q) || cancel_i))
        begin
            bset[B_DONE_BIT] = 1'b1;                                  // [RULE17] [RULE18]
            nxt_run_arm      = 1'b0;
        end
        nxt_abort = executing_i
                    && (locality_state_reg_i[4:2] != loc_state_q[4:2]); // [RULE19]
    end

    // Flag history and request tracking registers
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_ready_q    <= 1'b0;
            status_valid_q <= 1'b0;
            response_q     <= 1'b0;
            granted_q      <= 1'b0;
            loc_state_q    <= 5'h00;
            idle_q         <= 1'b1;
            busy_q         <= 1'b0;
            est_q          <= 1'b0;
            waited_ff      <= 1'b0;
            est_arm_ff     <= 1'b0;
            rdy_arm_ff     <= 1'b0;
            run_arm_ff     <= 1'b0;
            abort_ff       <= 1'b0;
        end
        else
        begin
            cmd_ready_q    <= cmd_ready_flag_i;
            status_valid_q <= status_valid_flag_i;
            response_q     <= response_ready_flag_i;
            granted_q      <= locality_granted_i;
            loc_state_q    <= locality_state_reg_i;
            idle_q         <= idle_flag_i;
            busy_q         <= start_busy_i;
            est_q          <= established_flag_i;
            waited_ff      <= nxt_waited;
            est_arm_ff     <= nxt_est_arm;
            rdy_arm_ff     <= nxt_rdy_arm;
            run_arm_ff     <= nxt_run_arm;
            abort_ff       <= nxt_abort;
        end
    end

    // Register file next values
    always_comb
    begin
        nxt_fgate = wr_fen ? wdata_i[GATE_BIT] : fgate_ff;                 // [RULE20]
        nxt_ftype = wr_fen ? wdata_i[TYPE_LO +: 2] : ftype_ff;             // [RULE1]
        nxt_fen   = wr_fen ? (wdata_i[7:0] & FIFO_CAUSE_MASK) : fen_ff;    // [RULE2]
        nxt_chan  = wr_vec ? wdata_i[3:0] : chan_ff;                       // [RULE8] [RULE9]
        nxt_bgate = wr_ben ? wdata_i[GATE_BIT] : bgate_ff;                 // [RULE11]
        nxt_ben   = wr_ben ? wdata_i[3:0] : ben_ff;                        // [RULE12]
        nxt_fsts  = w1c(fsts_ff, fset, wr_fsts, wdata_i[7:0])
                    & FIFO_CAUSE_MASK;                                     // [RULE4] [RULE10]
        nxt_bsts  = 4'(w1c({4'h0, bsts_ff}, {4'h0, bset}, wr_bsts,
                           wdata_i[7:0]));                                 // [RULE4]
        nxt_rdata = 32'h0000_0000;
        if (rd_i)
        begin
            unique case (addr_i)
                FIFO_EN_OFS:  nxt_rdata = {fgate_ff, 23'h0, fen_ff | {3'h0, ftype_ff, 3'h0}};
                FIFO_STS_OFS: nxt_rdata = {24'h0, fsts_ff};
                VECTOR_OFS:   nxt_rdata = {28'h0, chan_ff};
                BUF_EN_OFS:   nxt_rdata = {bgate_ff, 27'h0, ben_ff};
                BUF_STS_OFS:  nxt_rdata = {28'h0, bsts_ff};
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register file, one copy shared by all localities
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fgate_ff <= 1'b0;
            ftype_ff <= TYPE_RESET;
            fen_ff   <= 8'h00;
            fsts_ff  <= 8'h00;
            chan_ff  <= CHAN_RESET;
            bgate_ff <= 1'b0;
            ben_ff   <= 4'h0;
            bsts_ff  <= 4'h0;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            fgate_ff <= nxt_fgate;                                          // [RULE23]
            ftype_ff <= nxt_ftype;
            fen_ff   <= nxt_fen;
            fsts_ff  <= nxt_fsts;
            chan_ff  <= nxt_chan;
            bgate_ff <= nxt_bgate;
            ben_ff   <= nxt_ben;
            bsts_ff  <= nxt_bsts;
            rdata_ff <= nxt_rdata;
        end
    end

    // Interrupt sequencing
    irq_state_t state_ff, nxt_state;
    logic       pending, gate_move, eoi, act_ff, nxt_act;

    assign pending   = (fgate_ff && |(fsts_ff & fen_ff))
                       || (bgate_ff && |(bsts_ff & ben_ff));               // [RULE24]
    assign gate_move = (wr_fen && wdata_i[GATE_BIT] != fgate_ff)
                       || (wr_ben && wdata_i[GATE_BIT] != bgate_ff);
    assign eoi       = (wr_fsts && |(wdata_i[7:0] & FIFO_CAUSE_MASK))
                       || (wr_bsts && |wdata_i[3:0]);

    // One assertion per end-of-interrupt write
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:   if (pending && !gate_move) nxt_state = ST_ACTIVE;
            ST_ACTIVE: if (eoi) nxt_state = ST_GAP;                        // [RULE21]
            ST_GAP:    nxt_state = ST_IDLE;
            default:   nxt_state = ST_IDLE;
        endcase
        nxt_act = nxt_state == ST_ACTIVE && pending && !gate_move;         // [RULE22]
    end

    // Sequencer registers
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_IDLE;
            act_ff   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            act_ff   <= nxt_act;
        end
    end

    // Line shaping by type and channel
    irq_shaper u_shaper
    (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .active_i  (act_ff),
        .type_i    (ftype_ff),
        .channel_i (chan_ff),
        .line_o    (serial_irq_line_o),
        .line_oe_o (serial_irq_line_oe_o)
    );

    assign rdata_o      = rdata_ff;
    assign abort_cmd_o  = abort_ff;
    assign irq_active_o = act_ff;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_active;
        state_ff == ST_ACTIVE;
    endsequence

    sequence s_eoi_taken;
        s_active ##0 eoi;
    endsequence

    a_cmd_ready_cause: assert property (cmd_ready_flag_i && !cmd_ready_q
        |=> fsts_ff[CMD_RDY_BIT])                                          // [RULE3]
        else $error("command ready rise not latched");
    a_w1c_clear: assert property (wr_fsts && wdata_i[STSV_BIT]
        && !fset[STSV_BIT] |=> !fsts_ff[STSV_BIT])                         // [RULE4]
        else $error("status bit not cleared by one write");
    a_set_beats_clear: assert property (wr_bsts && bset[B_DONE_BIT]
        |=> bsts_ff[B_DONE_BIT])                                           // [RULE4]
        else $error("clear beat a same-cycle set");
    a_resp_needs_valid: assert property ($rose(fsts_ff[RESP_BIT])
        |-> $past(status_valid_flag_i))                                    // [RULE7]
        else $error("response cause without status valid");
    a_vector_high_zero: assert property (rd_i && addr_i == VECTOR_OFS
        |=> rdata_o[31:4] == 28'h0)                                        // [RULE9]
        else $error("vector upper bits not zero");
    a_fifo_sts_zero: assert property (rd_i && addr_i == FIFO_STS_OFS
        |=> rdata_o[31:8] == 24'h0 && rdata_o[6:3] == 4'h0)                // [RULE10]
        else $error("reserved status bits not zero");
    a_gate_off_quiet: assert property (!fgate_ff && !bgate_ff |=> !irq_active_o) // [RULE22]
        else $error("interrupt active with gates off");
    a_hold_until_eoi: assert property (s_active ##0 !eoi |=> s_active)     // [RULE21]
        else $error("left active state without end of interrupt");
    a_eoi_gap: assert property (s_eoi_taken |=> !irq_active_o ##1 !irq_active_o) // [RULE21]
        else $error("no gap after end of interrupt");
    a_no_unassigned_loc: assert property (!loc_state_q[0] |-> !bset[B_LOC_BIT]) // [RULE14]
        else $error("locality cause without assigned locality");
    a_abort_on_switch: assert property (executing_i
        && locality_state_reg_i[4:2] != loc_state_q[4:2] |=> abort_cmd_o)  // [RULE19]
        else $error("no abort on locality switch");
    a_request_rises: assert property (state_ff == ST_IDLE && pending && !gate_move
        |=> ##0 irq_active_o || eoi)                                       // [RULE24]
        else $error("pending enabled cause not requested");
endmodule : irq_ctrl

`default_nettype wire

//--- irq_shaper.sv
// Constants package and the interrupt line shaper
//
// How it works
// (RULE1) Type field bits 4:3 picks high, low, rising, falling; resets to low level.
// (RULE2) FIFO enable register: bit 7, 2, 1, 0 cause enables, reset zero.
// (RULE3) Command-ready flag rising sets FIFO status bit 7.
// (RULE4) Status cause bits clear on writing one; writing zero leaves them.
// (RULE5) Delayed locality grant sets FIFO status bit 2.
// (RULE6) Status-valid flag rising sets FIFO status bit 1.
// (RULE7) Response-ready rising with status-valid high sets FIFO status bit 0.
// (RULE8) Channel field bits 3:0 read/write, zero disables and floats the line.
// (RULE9) Vector bits 7:4 read zero and ignore writes.
// (RULE10) FIFO status bits 31:8 and 6:3 always read zero.
// (RULE11) Buffer enable bit 31 gates every buffer cause, reset zero.
// (RULE12) Buffer enable bits 3:0 read/write, bits 30:4 read zero.
// (RULE13) Change of locality state bits 4:2 sets buffer status bit 3.
// (RULE14) Grant with no locality assigned raises no locality change cause.
// (RULE15) Completed established-flag reset sets buffer status bit 2.
// (RULE16) Ready request finishing with idle low sets buffer status bit 1.
// (RULE17) Launched command done and start cleared sets buffer status bit 0.
// (RULE18) Command cancel of running command also sets buffer status bit 0.
// (RULE19) Active locality change while executing aborts the command.
// (RULE20) FIFO enable bit 31 is read/write global enable, reset zero; the code gates only the FIFO causes with it, not the buffer causes.
// (RULE21) No new interrupt after one until a status one-write arrives.
// (RULE22) Interrupt inactive while gate is zero and while it changes.
// (RULE23) One interrupt shared by all localities.
// (RULE24) Request when gate set and an enabled cause is pending.
package irq_pkg;
    // Register offsets, byte addresses
    localparam logic [7:0] FIFO_EN_OFS   = 8'h00;
    localparam logic [7:0] FIFO_STS_OFS  = 8'h04;
    localparam logic [7:0] VECTOR_OFS    = 8'h08;
    localparam logic [7:0] BUF_EN_OFS    = 8'h0c;
    localparam logic [7:0] BUF_STS_OFS   = 8'h10;
    // Field positions
    localparam int GATE_BIT      = 31;
    localparam int CMD_RDY_BIT   = 7;
    localparam int TYPE_LO       = 3;
    localparam int LOC_BIT       = 2;
    localparam int STSV_BIT      = 1;
    localparam int RESP_BIT      = 0;
    localparam int B_LOC_BIT     = 3;
    localparam int B_EST_BIT     = 2;
    localparam int B_RDY_BIT     = 1;
    localparam int B_DONE_BIT    = 0;
    // Masks of implemented cause bits
    localparam logic [7:0] FIFO_CAUSE_MASK = 8'h87;
    localparam logic [3:0] BUF_CAUSE_MASK  = 4'hf;
    // Reset values
    localparam logic [1:0] TYPE_RESET  = 2'h1;
    localparam logic [3:0] CHAN_RESET  = 4'h0;
    // Edge pulse length in clock cycles
    localparam int EDGE_PULSE_CYCLES = 1;
    // Start field launch code
    localparam logic [3:0] START_LAUNCH = 4'h1;

    typedef enum logic [1:0]
    {
        HIGH_LEVEL   = 2'b00,
        LOW_LEVEL    = 2'b01,
        RISING_EDGE  = 2'b10,
        FALLING_EDGE = 2'b11
    } irq_type_t;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_GAP    = 2'b10
    } irq_state_t;
endpackage : irq_pkg

`timescale 1ns/1ns
`default_nettype none

module irq_shaper
    import irq_pkg::*;
#(
    parameter int PULSE_CYCLES = EDGE_PULSE_CYCLES
)
(
    input  wire logic       clock_i,     // System clock
    input  wire logic       rst_i,       // Async reset, active high
    input  wire logic       active_i,    // Interrupt asserted level
    input  wire logic [1:0] type_i,      // Type and polarity select
    input  wire logic [3:0] channel_i,   // Serial channel, zero off
    output logic            line_o,      // Line level
    output logic            line_oe_o    // Line drive enable
);
    logic       line_ff;
    logic       nxt_line;
    logic       oe_ff;
    logic       nxt_oe;
    logic       act_ff;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    irq_type_t  kind;

    assign kind = irq_type_t'(type_i);

    // Level follows the request, edges give a short pulse
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_oe  = (channel_i != 4'h0);                         // [RULE8]
        if (active_i && !act_ff)
            nxt_cnt = 4'(PULSE_CYCLES);
        else if (cnt_ff != 4'h0)
            nxt_cnt = cnt_ff - 4'h1;
        unique case (kind)                                     // [RULE1]
            HIGH_LEVEL:   nxt_line = active_i;
            LOW_LEVEL:    nxt_line = !active_i;
            RISING_EDGE:  nxt_line = (nxt_cnt != 4'h0);
            FALLING_EDGE: nxt_line = (nxt_cnt == 4'h0);
        endcase
    end

    // Line registers
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            line_ff <= 1'b1;
            oe_ff   <= 1'b0;
            act_ff  <= 1'b0;
            cnt_ff  <= 4'h0;
        end
        else
        begin
            line_ff <= nxt_line;
            oe_ff   <= nxt_oe;
            act_ff  <= active_i;
            cnt_ff  <= nxt_cnt;
        end
    end

    assign line_o    = line_ff;
    assign line_oe_o = oe_ff;

    // Disabled channel never drives the line
    a_chan_off_float: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(channel_i) == 4'h0 |-> !line_oe_o)              // [RULE8]
        else $error("line driven with channel zero");
endmodule : irq_shaper

`default_nettype wire

//--- irq_receiver.sv
// Chipset side model of the serial interrupt line receiver
`timescale 1ns/1ns
`default_nettype none

module irq_receiver
(
    input  wire logic line_i,    // Line level from the device
    input  wire logic line_oe_i, // Device drive enable
    output logic      level_o    // Level seen on the wire
);
    // Pull-up holds the wire high whenever the device lets go
    assign level_o = line_oe_i ? line_i : 1'b1;
endmodule : irq_receiver

`default_nettype wire

//--- host_interface_interrupt_logic_tb.sv
// Testbench for the host interface interrupt logic
`timescale 1ns/1ns
`default_nettype none

module host_interface_interrupt_logic_tb;
    import irq_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cmd_rdy = 1'b0, sts_v = 1'b0, resp = 1'b0, loc_req = 1'b0, loc_gnt = 1'b0;
    logic [4:0]  loc_state = 5'h00;
    logic        est = 1'b0, est_req = 1'b0, rdy_req = 1'b0, idle = 1'b1;
    logic        st_wr = 1'b0, st_busy = 1'b0, cancel = 1'b0, exec = 1'b0;
    logic [3:0]  st_val = 4'h0;
    logic [31:0] rdata;
    logic        abort, irq, line, line_oe, wire_level;
    int          errors = 0, cmp_count = 0, cycles = 0, aborts = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    irq_ctrl u_irq_ctrl (.clock_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmd_ready_flag_i(cmd_rdy),
        .status_valid_flag_i(sts_v), .response_ready_flag_i(resp),
        .locality_request_i(loc_req), .locality_granted_i(loc_gnt),
        .locality_state_reg_i(loc_state), .established_flag_i(est), .est_reset_req_i(est_req),
        .ready_req_i(rdy_req), .idle_flag_i(idle), .start_write_i(st_wr),
        .start_value_i(st_val), .start_busy_i(st_busy), .cancel_i(cancel), .executing_i(exec),
        .abort_cmd_o(abort), .irq_active_o(irq), .serial_irq_line_o(line),
        .serial_irq_line_oe_o(line_oe));

    irq_receiver u_irq_receiver (.line_i(line), .line_oe_i(line_oe), .level_o(wire_level));

    // Abort pulse counter and run time limit
    always @(posedge clk)
    begin
        cycles++;
        if (abort === 1'b1)
            aborts++;
        if (cycles == 5000)
        begin
            errors++;
            final_report();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Compare irq, the wire level or the abort count mid-cycle, then return on the next rising edge
    task automatic look(input string what, input logic [31:0] exp, input int sel);
        @(negedge clk);
        if (sel == 0)
            chk(what, exp, {31'h0, irq});
        else if (sel == 1)
            chk(what, exp, {31'h0, wire_level});
        else
            chk(what, exp, 32'(aborts));
        @(posedge clk);
    endtask : look

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read, then compare the word in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), exp, rdata);
        @(posedge clk);
    endtask : rchk

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        tick(5);
        rst <= 1'b0;
        rchk(FIFO_EN_OFS, 32'h00000008);
        rchk(FIFO_STS_OFS, 32'h0);
        rchk(VECTOR_OFS, 32'h0);
        rchk(BUF_EN_OFS, 32'h0);
        rchk(BUF_STS_OFS, 32'h0);
        rchk(8'h14, 32'h0);
        look("wire idle", 32'h1, 1);
        $display("test reset values done");
        wr_reg(FIFO_EN_OFS, 32'hffffffff);
        rchk(FIFO_EN_OFS, 32'h8000009f);
        wr_reg(VECTOR_OFS, 32'hff);
        rchk(VECTOR_OFS, 32'h0f);
        wr_reg(BUF_EN_OFS, 32'hffffffff);
        rchk(BUF_EN_OFS, 32'h8000000f);
        wr_reg(8'h14, 32'hffffffff);
        rchk(8'h14, 32'h0);
        for (int t = 0; t < 4; t++)
        begin
            wr_reg(FIFO_EN_OFS, 32'(t) << TYPE_LO);
            rchk(FIFO_EN_OFS, 32'(t) << TYPE_LO);
        end
        wr_reg(BUF_EN_OFS, 32'h0);
        $display("test register fields done");
        loc_state <= 5'b01001;
        tick(2);
        cmd_rdy <= 1'b1;
        sts_v <= 1'b1;
        tick(2);
        resp <= 1'b1;
        loc_req <= 1'b1;
        tick(2);
        loc_gnt <= 1'b1;
        tick(3);
        rchk(FIFO_STS_OFS, 32'h87);
        rchk(BUF_STS_OFS, 32'h0);
        wr_reg(FIFO_STS_OFS, 32'h0);
        rchk(FIFO_STS_OFS, 32'h87);
        wr_reg(FIFO_STS_OFS, 32'h80);
        rchk(FIFO_STS_OFS, 32'h07);
        wr_reg(FIFO_STS_OFS, 32'hffffffff);
        rchk(FIFO_STS_OFS, 32'h0);
        $display("test fifo causes done");
        cmd_rdy <= 1'b0;
        sts_v <= 1'b0;
        resp <= 1'b0;
        loc_req <= 1'b0;
        wr_reg(VECTOR_OFS, 32'h3);
        wr_reg(FIFO_EN_OFS, 32'h8000008a);
        cmd_rdy <= 1'b1;
        tick(4);
        look("irq", 32'h1, 0);
        look("wire low", 32'h0, 1);
        sts_v <= 1'b1;
        tick(3);
        wr_reg(FIFO_STS_OFS, 32'h80);
        look("irq eoi", 32'h0, 0);
        tick(3);
        look("irq again", 32'h1, 0);
        wr_reg(FIFO_STS_OFS, 32'h02);
        tick(2);
        look("irq done", 32'h0, 0);
        cmd_rdy <= 1'b0;
        wr_reg(FIFO_EN_OFS, 32'h0000008a);
        cmd_rdy <= 1'b1;
        tick(4);
        look("irq gated", 32'h0, 0);
        wr_reg(FIFO_EN_OFS, 32'h8000008a);
        look("irq gate change", 32'h0, 0);
        tick(3);
        look("irq ungated", 32'h1, 0);
        wr_reg(FIFO_EN_OFS, 32'h80000082);
        tick(1);
        look("wire high level", 32'h1, 1);
        wr_reg(FIFO_STS_OFS, 32'hff);
        wr_reg(FIFO_EN_OFS, 32'h0);
        tick(2);
        look("irq off", 32'h0, 0);
        $display("test fifo interrupt done");
        wr_reg(BUF_EN_OFS, 32'h8000000f);
        exec <= 1'b1;
        loc_state <= 5'b00101;
        tick(3);
        look("aborts", 32'h1, 2);
        exec <= 1'b0;
        rdy_req <= 1'b1;
        tick(1);
        rdy_req <= 1'b0;
        idle <= 1'b0;
        est_req <= 1'b1;
        tick(1);
        est_req <= 1'b0;
        est <= 1'b1;
        st_wr <= 1'b1;
        st_val <= START_LAUNCH;
        st_busy <= 1'b1;
        tick(1);
        st_wr <= 1'b0;
        tick(2);
        st_busy <= 1'b0;
        tick(3);
        rchk(BUF_STS_OFS, 32'hf);
        look("buffer irq", 32'h1, 0);
        wr_reg(BUF_STS_OFS, 32'hf);
        tick(2);
        rchk(BUF_STS_OFS, 32'h0);
        look("buffer irq off", 32'h0, 0);
        // Launch a command, then cancel it while it runs
        exec <= 1'b1;
        st_wr <= 1'b1;
        st_busy <= 1'b1;
        tick(1);
        st_wr <= 1'b0;
        cancel <= 1'b1;
        tick(1);
        cancel <= 1'b0;
        st_busy <= 1'b0;
        tick(3);
        rchk(BUF_STS_OFS, 32'h1);
        exec <= 1'b0;
        $display("test buffer causes done");
        final_report();
    end
endmodule : host_interface_interrupt_logic_tb

`default_nettype wire
